// *** design/pis_pkg.sv ***
// constants and carriers for the peripheral interrupt source block
// How it works
// - timer wrap to zero after modulo sets flag
// - channel capture or compare sets channel flag
// - serial byte into receive register sets flag
// - serial byte into shifter sets empty flag
// - select pin misuse sets fault when enabled
// - byte before read sets overflow; shared enable
// - async data handed to shifter sets flag
// - all empty, no break/idle: done flag
// - async character loaded sets receive full
// - ten or eleven ones set quiet flag
// - unread character overrun raises serial error
// - noise on any bit raises serial error
// - zero stop bit raises serial error
// - parity failure raises serial error
// - any keyboard pin low latches request
// - converter interrupts when enabled, else done flag
// - timebase rollover sets tick; ack clears
// - each empty transmit slot gated separately
// - correct message received sets receive flag
// - bus activity while asleep sets wake flag
// - both buffers full plus new frame: overrun
// - error counter thresholds set warn/passive/off
package pis_pkg;

    // ----
    // register map (byte addresses)
    // ----
    localparam logic [3:0]  OFS_ENABLE = 4'h0;
    localparam logic [3:0]  OFS_FLAGS  = 4'h4;
    localparam logic [3:0]  OFS_CTRL   = 4'h8;
    localparam logic [3:0]  OFS_STATUS = 4'hc;
    localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
    localparam logic [7:0]  CTRL_RST   = 8'h00;

    // ----
    // flag and enable bit positions
    // ----
    localparam int F_WRAP = 0, F_CH0 = 1, F_CH1 = 2, F_SPRX = 3;
    localparam int F_SPTX = 4, F_SFLT = 5, F_SOVF = 6, F_TXDE = 7;
    localparam int F_TXDN = 8, F_RXF = 9, F_QUIET = 10, F_ORUN = 11;
    localparam int F_NOISE = 12, F_STOP = 13, F_PAR = 14, F_KBD = 15;
    localparam int F_ADC = 16, F_TICK = 17, F_CRX = 18, F_WAKE = 19;
    localparam int F_BOVR = 20, F_RWRN = 21, F_TWRN = 22, F_RPAS = 23;
    localparam int F_TPAS = 24, F_BOFF = 25, F_SLOT = 26;
    localparam int NFLAG = 26;

    // ctrl and status fields
    localparam int C_FAULT_EN = 0, C_SPI_MASTER = 1, C_NINE_BIT = 2;
    localparam int C_TB_EN = 3, C_RATE = 4, C_TICK_ACK = 7;
    localparam int S_SLOT = 0, S_CONV_DONE = 3, S_RX_PIN = 4;

    // ----
    // thresholds and timing
    // ----
    localparam logic [15:0] TIM_WRAP_VALUE = 16'h0000;
    localparam logic [3:0]  QUIET_BITS_8   = 4'ha;
    localparam logic [3:0]  QUIET_BITS_9   = 4'hb;
    localparam logic [7:0]  CAN_WARN       = 8'h60;
    localparam logic [7:0]  CAN_PASSIVE    = 8'h7f;
    localparam logic [8:0]  CAN_BUSOFF     = 9'h0ff;
    localparam int          TICK_BASE      = 3;
    localparam int          TB_WIDTH       = 18;

    // ----
    // carriers
    // ----
    typedef struct packed {
        logic [1:0] tim_ch;
        logic       spi_rx_load;
        logic       spi_tx_load;
        logic       spi_byte_in;
        logic       spi_busy;
        logic       sci_tx_load;
        logic       sci_shift_empty;
        logic       sci_data_empty;
        logic       sci_special;
        logic       sci_rx_load;
        logic       sci_bit_tick;
        logic       sci_noise;
        logic       sci_stop_strobe;
        logic       sci_stop_bit;
        logic       sci_parity_err;
        logic       adc_done;
        logic       adc_read;
        logic [2:0] can_tx_empty;
        logic       can_rx_done;
        logic       can_sleep;
        logic       can_bus_active;
        logic       can_both_full;
        logic       can_rx_start;
    } periph_ev_s;

    typedef struct packed {
        logic tim_ch0;
        logic tim_ch1;
        logic tim_wrap;
        logic spi_rx;
        logic spi_tx;
        logic sci_err;
        logic sci_rx;
        logic sci_tx;
        logic kbd;
        logic adc;
        logic tick;
        logic can_wake;
        logic can_err;
        logic can_rx;
        logic can_tx;
    } irq_req_s;

endpackage

// *** design/periph_irq_sources.sv ***
// interrupt flags, enables and request gating for peripheral sources
`timescale 1ns/100ps
module periph_irq_sources #(
    parameter int TIM_W = 16
) (
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst_n,
    // avalon-mm slave
    input  wire logic [3:0]           i_address,
    input  wire logic                 i_read,
    input  wire logic                 i_write,
    input  wire logic [31:0]          i_writedata,
    input  wire logic [3:0]           i_byteenable,
    output logic      [31:0]          o_readdata,
    output logic                      o_waitrequest,
    // peripheral events, same clock
    input  wire pis_pkg::periph_ev_s  i_ev,
    input  wire logic [TIM_W-1:0]     i_tim_count,
    input  wire logic [TIM_W-1:0]     i_tim_modulo,
    input  wire logic [7:0]           i_can_rx_err,
    input  wire logic [8:0]           i_can_tx_err,
    // pins
    input  wire logic                 i_slave_select_pin,
    input  wire logic                 i_rx_pin,
    input  wire logic [7:0]           i_keyboard_input_pins,
    // requests to cpu
    output pis_pkg::irq_req_s         o_irq,
    output logic                      o_conversion_done_flag
);

    // ----
    // registers and state
    // ----
    logic [31:0]                  enable;
    logic [7:0]                   ctrl;
    logic [pis_pkg::NFLAG-1:0]    flags;
    logic [pis_pkg::NFLAG-1:0]    next_flags;
    logic [pis_pkg::NFLAG-1:0]    set_v;
    logic [pis_pkg::NFLAG-1:0]    clr_v;
    logic [31:0]                  rd_mux;
    logic                         wr_take;
    logic [31:0]                  be_mask;
    logic                         tick_ack;

    logic [1:0]                   ss_sync;
    logic [1:0]                   rx_sync;
    logic [7:0]                   kbd_s1;
    logic [7:0]                   kbd_s2;
    logic                         ss_d;
    logic [TIM_W-1:0]             tim_prev;
    logic                         done_cond_d;
    logic [3:0]                   ones_cnt;
    logic [7:0]                   rx_err_d;
    logic [8:0]                   tx_err_d;
    logic [pis_pkg::TB_WIDTH-1:0] tb_cnt;
    logic                         tb_roll;
    logic                         done_cond;
    logic [3:0]                   quiet_need;

    // ----
    // helpers
    // ----
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // low bits that must be all ones for a rollover at this rate
    function automatic logic [pis_pkg::TB_WIDTH-1:0] tb_span(input logic [2:0] sel);
        int n;
        n = pis_pkg::TICK_BASE + 2 * int'(sel);
        tb_span = pis_pkg::TB_WIDTH'((64'h1 << n) - 64'h1);
    endfunction

    // rising crossing of a threshold on a counter
    function automatic logic crossed(input logic [8:0] prev, input logic [8:0] cur,
                                     input logic [8:0] lim, input logic gt);
        if (gt)
            crossed = (cur > lim) && !(prev > lim);
        else
            crossed = (cur >= lim) && !(prev >= lim);
    endfunction

    // ----
    // pin synchronisers
    // ----
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ss_sync <= 2'h3;
            rx_sync <= 2'h3;
            kbd_s1  <= 8'hff;
            kbd_s2  <= 8'hff;
        end else begin
            ss_sync <= {ss_sync[0], i_slave_select_pin};
            rx_sync <= {rx_sync[0], i_rx_pin};
            kbd_s1  <= i_keyboard_input_pins;
            kbd_s2  <= kbd_s1;
        end
    end

    // ----
    // history of inputs for edge and crossing detection
    // ----
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ss_d        <= 1'h1;
            tim_prev    <= '0;
            done_cond_d <= 1'h0;
            rx_err_d    <= 8'h00;
            tx_err_d    <= 9'h000;
        end else begin
            ss_d        <= ss_sync[1];
            tim_prev    <= i_tim_count;
            done_cond_d <= done_cond;
            rx_err_d    <= i_can_rx_err;
            tx_err_d    <= i_can_tx_err;
        end
    end

    // break or idle in progress blocks completion
    assign done_cond = i_ev.sci_shift_empty && i_ev.sci_data_empty && !i_ev.sci_special;

    // ----
    // quiet line counter on the receive pin
    // ----
    assign quiet_need = ctrl[pis_pkg::C_NINE_BIT] ? pis_pkg::QUIET_BITS_9
                                                  : pis_pkg::QUIET_BITS_8;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ones_cnt <= 4'h0;
        end else if (i_ev.sci_bit_tick) begin
            if (!rx_sync[1])
                ones_cnt <= 4'h0;
            else if (ones_cnt != 4'hf)
                ones_cnt <= ones_cnt + 4'h1;
        end
    end

    // ----
    // timebase counter chain
    // ----
    assign tb_roll = ctrl[pis_pkg::C_TB_EN]
                  && ((tb_cnt & tb_span(ctrl[pis_pkg::C_RATE +: 3]))
                      == tb_span(ctrl[pis_pkg::C_RATE +: 3]));

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n)
            tb_cnt <= '0;
        else if (ctrl[pis_pkg::C_TB_EN])
            tb_cnt <= tb_cnt + pis_pkg::TB_WIDTH'(1);
        else
            tb_cnt <= '0;
    end

    // ----
    // flag set sources
    // ----
    always_comb begin
        set_v = '0;
        set_v[pis_pkg::F_WRAP] = (i_tim_count == TIM_W'(pis_pkg::TIM_WRAP_VALUE))
                              && (tim_prev == i_tim_modulo)
                              && (tim_prev != i_tim_count);
        set_v[pis_pkg::F_CH0]  = i_ev.tim_ch[0];
        set_v[pis_pkg::F_CH1]  = i_ev.tim_ch[1];
        set_v[pis_pkg::F_SPRX] = i_ev.spi_rx_load;
        set_v[pis_pkg::F_SPTX] = i_ev.spi_tx_load;
        if (ctrl[pis_pkg::C_FAULT_EN]) begin
            if (ctrl[pis_pkg::C_SPI_MASTER])
                set_v[pis_pkg::F_SFLT] = !ss_sync[1];
            else
                set_v[pis_pkg::F_SFLT] = i_ev.spi_busy && ss_sync[1] && !ss_d;
        end
        set_v[pis_pkg::F_SOVF] = i_ev.spi_byte_in && flags[pis_pkg::F_SPRX];
        set_v[pis_pkg::F_TXDE] = i_ev.sci_tx_load;
        set_v[pis_pkg::F_TXDN] = done_cond && !done_cond_d;
        set_v[pis_pkg::F_RXF]  = i_ev.sci_rx_load;
        set_v[pis_pkg::F_QUIET] = i_ev.sci_bit_tick && rx_sync[1]
                               && (ones_cnt + 4'h1 == quiet_need);
        set_v[pis_pkg::F_ORUN] = i_ev.sci_rx_load && flags[pis_pkg::F_RXF];
        set_v[pis_pkg::F_NOISE] = i_ev.sci_noise;
        set_v[pis_pkg::F_STOP] = i_ev.sci_stop_strobe && !i_ev.sci_stop_bit;
        set_v[pis_pkg::F_PAR]  = i_ev.sci_parity_err;
        set_v[pis_pkg::F_KBD]  = !(&kbd_s2);
        set_v[pis_pkg::F_ADC]  = i_ev.adc_done && enable[pis_pkg::F_ADC];
        set_v[pis_pkg::F_TICK] = tb_roll;
        set_v[pis_pkg::F_CRX]  = i_ev.can_rx_done;
        set_v[pis_pkg::F_WAKE] = i_ev.can_sleep && i_ev.can_bus_active;
        set_v[pis_pkg::F_BOVR] = i_ev.can_both_full && i_ev.can_rx_start;
        set_v[pis_pkg::F_RWRN] = crossed({1'h0, rx_err_d}, {1'h0, i_can_rx_err},
                                         {1'h0, pis_pkg::CAN_WARN}, 1'h0);
        set_v[pis_pkg::F_TWRN] = crossed(tx_err_d, i_can_tx_err,
                                         {1'h0, pis_pkg::CAN_WARN}, 1'h0);
        set_v[pis_pkg::F_RPAS] = crossed({1'h0, rx_err_d}, {1'h0, i_can_rx_err},
                                         {1'h0, pis_pkg::CAN_PASSIVE}, 1'h1);
        set_v[pis_pkg::F_TPAS] = crossed(tx_err_d, i_can_tx_err,
                                         {1'h0, pis_pkg::CAN_PASSIVE}, 1'h1);
        set_v[pis_pkg::F_BOFF] = crossed(tx_err_d, i_can_tx_err,
                                         pis_pkg::CAN_BUSOFF, 1'h1);
    end

    // ----
    // bus access
    // ----
    // write lands on the edge where waitrequest is seen low
    assign wr_take  = i_write && !o_waitrequest;
    assign be_mask  = lane_mask(i_byteenable);
    assign tick_ack = wr_take && (i_address == pis_pkg::OFS_CTRL)
                   && i_byteenable[0] && i_writedata[pis_pkg::C_TICK_ACK];

    always_comb begin
        clr_v = '0;
        if (wr_take && i_address == pis_pkg::OFS_FLAGS)
            clr_v = i_writedata[pis_pkg::NFLAG-1:0] & be_mask[pis_pkg::NFLAG-1:0];
        // tick clears only through its own acknowledge
        clr_v[pis_pkg::F_TICK] = tick_ack;
    end

    // a source event in the clearing cycle survives
    assign next_flags = (flags & ~clr_v) | set_v;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n)
            flags <= '0;
        else
            flags <= next_flags;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            enable <= pis_pkg::ENABLE_RST;
            ctrl   <= pis_pkg::CTRL_RST;
        end else if (wr_take) begin
            if (i_address == pis_pkg::OFS_ENABLE)
                enable <= (enable & ~be_mask) | (i_writedata & be_mask);
            if (i_address == pis_pkg::OFS_CTRL && i_byteenable[0])
                ctrl <= {1'h0, i_writedata[6:0]};
        end
    end

    // completion bit used only while the converter interrupt is off
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n)
            o_conversion_done_flag <= 1'h0;
        else if (i_ev.adc_done && !enable[pis_pkg::F_ADC])
            o_conversion_done_flag <= 1'h1;
        else if (i_ev.adc_read || enable[pis_pkg::F_ADC])
            o_conversion_done_flag <= 1'h0;
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (i_address)
            pis_pkg::OFS_ENABLE: rd_mux = enable;
            pis_pkg::OFS_FLAGS: begin
                rd_mux[pis_pkg::NFLAG-1:0] = flags;
                rd_mux[pis_pkg::F_SLOT +: 3] = i_ev.can_tx_empty;
            end
            pis_pkg::OFS_CTRL: rd_mux[7:0] = ctrl;
            pis_pkg::OFS_STATUS: begin
                rd_mux[pis_pkg::S_SLOT +: 3] = i_ev.can_tx_empty;
                rd_mux[pis_pkg::S_CONV_DONE] = o_conversion_done_flag;
                rd_mux[pis_pkg::S_RX_PIN]    = rx_sync[1];
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // one wait cycle, then a single-cycle answer
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_waitrequest <= 1'h1;
            o_readdata    <= 32'h0000_0000;
        end else if ((i_read || i_write) && o_waitrequest) begin
            o_waitrequest <= 1'h0;
            o_readdata    <= i_read ? rd_mux : 32'h0000_0000;
        end else begin
            o_waitrequest <= 1'h1;
        end
    end

    // ----
    // request gating
    // ----
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_irq <= '0;
        end else begin
            o_irq.tim_wrap <= flags[pis_pkg::F_WRAP] && enable[pis_pkg::F_WRAP];
            o_irq.tim_ch0  <= flags[pis_pkg::F_CH0] && enable[pis_pkg::F_CH0];
            o_irq.tim_ch1  <= flags[pis_pkg::F_CH1] && enable[pis_pkg::F_CH1];
            o_irq.spi_rx   <= |(flags[pis_pkg::F_SPRX +: 1] & enable[pis_pkg::F_SPRX +: 1])
                           || ((flags[pis_pkg::F_SFLT] || flags[pis_pkg::F_SOVF])
                               && enable[pis_pkg::F_SOVF]);
            o_irq.spi_tx   <= flags[pis_pkg::F_SPTX] && enable[pis_pkg::F_SPTX];
            o_irq.sci_err  <= |(flags[pis_pkg::F_ORUN +: 4]
                                & enable[pis_pkg::F_ORUN +: 4]);
            o_irq.sci_rx   <= |(flags[pis_pkg::F_RXF +: 2]
                                & enable[pis_pkg::F_RXF +: 2]);
            o_irq.sci_tx   <= |(flags[pis_pkg::F_TXDE +: 2]
                                & enable[pis_pkg::F_TXDE +: 2]);
            o_irq.kbd      <= flags[pis_pkg::F_KBD] && enable[pis_pkg::F_KBD];
            o_irq.adc      <= flags[pis_pkg::F_ADC] && enable[pis_pkg::F_ADC];
            o_irq.tick     <= flags[pis_pkg::F_TICK] && enable[pis_pkg::F_TICK];
            o_irq.can_wake <= flags[pis_pkg::F_WAKE] && enable[pis_pkg::F_WAKE];
            o_irq.can_err  <= |(flags[pis_pkg::F_BOVR +: 6]
                                & enable[pis_pkg::F_BOVR +: 6]);
            o_irq.can_rx   <= flags[pis_pkg::F_CRX] && enable[pis_pkg::F_CRX];
            o_irq.can_tx   <= |(i_ev.can_tx_empty & enable[pis_pkg::F_SLOT +: 3]);
        end
    end

endmodule

// *** verif/pis_chk_assertions.sv ***
// concurrent checks on the interrupt source block ports
`timescale 1ns/100ps
module pis_chk (
    // clock and reset
    input wire logic                i_sys_clk,
    input wire logic                i_rst_n,
    // bus
    input wire logic [3:0]          i_address,
    input wire logic                i_read,
    input wire logic                i_write,
    input wire logic [31:0]         i_writedata,
    input wire logic [3:0]          i_byteenable,
    input wire logic                o_waitrequest,
    // events and requests
    input wire pis_pkg::periph_ev_s i_ev,
    input wire logic [7:0]          i_keyboard_input_pins,
    input wire logic [7:0]          i_can_rx_err,
    input wire pis_pkg::irq_req_s   o_irq
);
    // ----
    // enable shadow, snooped at the edge a write lands
    // ----
    logic [31:0] en;
    logic [31:0] lanes;
    logic        slot_req;
    assign slot_req = |(i_ev.can_tx_empty & en[28:26]);
    assign lanes = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                    {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            en <= '0;
        end else if (i_write && !o_waitrequest && i_address == pis_pkg::OFS_ENABLE) begin
            en <= (en & ~lanes) | (i_writedata & lanes);
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    bus_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("bus request not answered");
    wait_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low too long");
    ch0_request_a: assert property (en[1] && i_ev.tim_ch[0] && !i_write |-> ##2 o_irq.tim_ch0)
        else $error("channel 0 request missing");
    spi_rx_a: assert property (en[3] && i_ev.spi_rx_load && !i_write |-> ##2 o_irq.spi_rx)
        else $error("serial receive request missing");
    wrap_gate_a: assert property (o_irq.tim_wrap |-> $past(en[0]) || $past(en[0], 2))
        else $error("wrap request while disabled");
    ch1_gate_a: assert property (o_irq.tim_ch1 |-> $past(en[2]) || $past(en[2], 2))
        else $error("channel 1 request while disabled");
    kbd_request_a: assert property (en[15] && i_keyboard_input_pins != 8'hff && !i_write
        |-> ##[2:5] o_irq.kbd)
        else $error("keyboard request missing");
    slot_follow_a: assert property (!$past(i_write)
        |-> o_irq.can_tx == $past(slot_req))
        else $error("slot request mismatch");
    warn_request_a: assert property (en[21] && !i_write && i_can_rx_err >= pis_pkg::CAN_WARN
        && $past(i_can_rx_err) < pis_pkg::CAN_WARN |-> ##[1:3] o_irq.can_err)
        else $error("warning request missing");
    cover property (o_irq.sci_err);
    cover property (o_irq.can_tx);
    cover property (o_irq.tick);
endmodule

bind periph_irq_sources pis_chk i_pis_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_waitrequest(o_waitrequest), .i_ev(i_ev),
    .i_keyboard_input_pins(i_keyboard_input_pins), .i_can_rx_err(i_can_rx_err),
    .o_irq(o_irq));

// *** verif/periph_model.sv ***
// peripheral side model: timer, event strobes, error counters and pins
`timescale 1ns/100ps
module periph_model (
    // clock and reset
    input  wire logic           i_sys_clk,
    input  wire logic           i_rst_n,
    // toward the block
    output pis_pkg::periph_ev_s o_ev,
    output logic [15:0]         o_tim_count,
    output logic [15:0]         o_tim_modulo,
    output logic [7:0]          o_can_rx_err,
    output logic [8:0]          o_can_tx_err,
    output logic                o_slave_select_pin,
    output logic                o_rx_pin,
    output logic [7:0]          o_keyboard_input_pins
);
    assign o_tim_modulo = 16'h0007;
    initial begin
        o_ev = '0;
        o_can_rx_err = 8'h00;
        o_can_tx_err = 9'h000;
        o_slave_select_pin = 1'b1;
        o_rx_pin = 1'b1;
        o_keyboard_input_pins = 8'hff;
    end
    // short modulo keeps wraps frequent
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || o_tim_count == o_tim_modulo) begin
            o_tim_count <= 16'h0000;
        end else begin
            o_tim_count <= o_tim_count + 16'h0001;
        end
    end
    // one event kind per call; pins pulse low for a single cycle
    task automatic fire(input int k);
        @(posedge i_sys_clk);
        case (k)
            0: o_ev.tim_ch[0] <= 1'b1;
            1: o_ev.tim_ch[1] <= 1'b1;
            2, 13: o_ev.spi_rx_load <= 1'b1;
            3: o_ev.spi_tx_load <= 1'b1;
            4: o_ev.sci_tx_load <= 1'b1;
            5, 14: o_ev.sci_rx_load <= 1'b1;
            6: o_ev.sci_noise <= 1'b1;
            7: o_ev.sci_stop_strobe <= 1'b1;
            8: o_ev.sci_parity_err <= 1'b1;
            9: o_ev.adc_done <= 1'b1;
            10: o_ev.can_rx_done <= 1'b1;
            11: {o_ev.can_sleep, o_ev.can_bus_active} <= 2'b11;
            12: {o_ev.can_both_full, o_ev.can_rx_start} <= 2'b11;
            15: o_slave_select_pin <= 1'b0;
            16: o_keyboard_input_pins <= 8'hf7;
            17: {o_ev.sci_shift_empty, o_ev.sci_data_empty} <= 2'b11;
            18: repeat (10) begin
                o_ev.sci_bit_tick <= 1'b1;
                @(posedge i_sys_clk);
                o_ev.sci_bit_tick <= 1'b0;
                @(posedge i_sys_clk);
            end
            19: o_can_rx_err <= 8'h7f;
            20: o_can_rx_err <= 8'h80;
            21: o_can_tx_err <= 9'h100;
            22: o_ev.adc_read <= 1'b1;
            default: ;
        endcase
        @(posedge i_sys_clk);
        o_ev <= '0;
        o_slave_select_pin <= 1'b1;
        o_keyboard_input_pins <= 8'hff;
        if (k == 13 || k == 14) begin
            @(posedge i_sys_clk);
            @(posedge i_sys_clk);
            o_ev.spi_byte_in <= (k == 13);
            o_ev.sci_rx_load <= (k == 14);
            @(posedge i_sys_clk);
            o_ev <= '0;
        end
    endtask
    task automatic slots(input logic [2:0] s);
        @(posedge i_sys_clk);
        o_ev.can_tx_empty <= s;
    endtask
endmodule

// *** verif/periph_irq_sources_tb.sv ***
// self-checking bench for the peripheral interrupt source block
`timescale 1ns/100ps
module periph_irq_sources_tb;
    logic                i_sys_clk   = 1'b0;
    logic                i_rst_n     = 1'b0;
    logic [3:0]          i_address   = 4'h0;
    logic                i_read      = 1'b0;
    logic                i_write     = 1'b0;
    logic [31:0]         i_writedata = 32'h0;
    logic [31:0]         o_readdata;
    logic                o_waitrequest;
    pis_pkg::periph_ev_s ev;
    pis_pkg::irq_req_s   o_irq;
    logic                done_flag, ss, rxp;
    logic [15:0]         cnt, modulo;
    logic [7:0]          rx_err, kbd;
    logic [8:0]          tx_err;
    int                  n_errors   = 0;
    int                  num_checks = 0;
    // flags raised and request bit of each event kind, in firing order
    logic [31:0] fm [23] = '{32'h2, 32'h4, 32'h8, 32'h10, 32'h80, 32'h200, 32'h1000,
        32'h2000, 32'h4000, 32'h10000, 32'h40000, 32'h80000, 32'h100000, 32'h48, 32'ha00,
        32'h20, 32'h8000, 32'h100, 32'h400, 32'h200000, 32'h800000, 32'h3400000, 32'h20000};
    int ib [23] = '{14, 13, 11, 10, 7, 8, 9, 9, 9, 5, 1, 3, 2, 11, 9, 11, 6, 7, 8, 2, 2, 2, 4};
    always #50 i_sys_clk = ~i_sys_clk;
    periph_model i_periph_model (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .o_ev(ev),
        .o_tim_count(cnt), .o_tim_modulo(modulo), .o_can_rx_err(rx_err),
        .o_can_tx_err(tx_err), .o_slave_select_pin(ss), .o_rx_pin(rxp),
        .o_keyboard_input_pins(kbd));
    periph_irq_sources i_periph_irq_sources (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(4'hf), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_ev(ev), .i_tim_count(cnt), .i_tim_modulo(modulo),
        .i_can_rx_err(rx_err), .i_can_tx_err(tx_err), .i_slave_select_pin(ss),
        .i_rx_pin(rxp), .i_keyboard_input_pins(kbd), .o_irq(o_irq),
        .o_conversion_done_flag(done_flag));
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge i_sys_clk);
        i_address <= a;
        i_write <= wr;
        i_read <= !wr;
        i_writedata <= wd;
        do @(posedge i_sys_clk); while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(nm, exp, x & m);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_errors++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rdc("enable", pis_pkg::OFS_ENABLE, 32'hffffffff, pis_pkg::ENABLE_RST);
        rdc("ctrl", pis_pkg::OFS_CTRL, 32'hffffffff, {24'h0, pis_pkg::CTRL_RST});
        rdc("flags", pis_pkg::OFS_FLAGS, 32'h1ffffffe, 32'h0);
        rdc("unmapped", 4'h2, 32'hffffffff, 32'h0);
        repeat (20) @(posedge i_sys_clk);
        check("masked", 32'h0, {17'h0, o_irq});
        wr(pis_pkg::OFS_ENABLE, 32'h1);
        repeat (20) @(posedge i_sys_clk);
        check("wrap", 32'h1, {31'h0, o_irq.tim_wrap});
        $display("reset and wrap test done");
        wr(pis_pkg::OFS_ENABLE, 32'h1fffffdf);
        wr(4'h2, 32'h0);
        rdc("enable", pis_pkg::OFS_ENABLE, 32'hffffffdf, 32'h1fffffdf);
        wr(pis_pkg::OFS_CTRL, 32'h3);
        for (int k = 0; k < 23; k++) begin
            if (k == 22) wr(pis_pkg::OFS_CTRL, 32'hb);
            i_periph_model.fire(k);
            repeat (12) @(posedge i_sys_clk);
            check("irq", 32'h1, {31'h0, o_irq[ib[k]]});
            rdc("flags", pis_pkg::OFS_FLAGS, 32'h03fffffe, fm[k]);
            if (k == 22) wr(pis_pkg::OFS_CTRL, 32'h83);
            else wr(pis_pkg::OFS_FLAGS, fm[k]);
            repeat (4) @(posedge i_sys_clk);
            check("irq clear", 32'h0, {31'h0, o_irq[ib[k]]});
        end
        $display("event source test done");
        i_periph_model.slots(3'b010);
        repeat (3) @(posedge i_sys_clk);
        check("slot irq", 32'h1, {31'h0, o_irq.can_tx});
        rdc("status", pis_pkg::OFS_STATUS, 32'h7, 32'h2);
        rdc("slot flags", pis_pkg::OFS_FLAGS, 32'h1c000000, 32'h08000000);
        wr(pis_pkg::OFS_ENABLE, 32'h17ffffdf);
        repeat (3) @(posedge i_sys_clk);
        check("slot masked", 32'h0, {31'h0, o_irq.can_tx});
        wr(pis_pkg::OFS_ENABLE, 32'h0);
        i_periph_model.fire(9);
        repeat (6) @(posedge i_sys_clk);
        check("conv done", 32'h1, {31'h0, done_flag});
        check("adc irq", 32'h0, {31'h0, o_irq.adc});
        i_periph_model.fire(22);
        repeat (2) @(posedge i_sys_clk);
        check("conv read", 32'h0, {31'h0, done_flag});
        $display("slot and converter test done");
        conclude();
    end
endmodule
